// [hw/serial_link_control_regs.sv]
// Purpose: APB register bank controlling the serial link output subsystem
// Assumes: 125 MHz pclk, sync pins asynchronous, mode decode given by simple E/F/lane table
// Notes: zero wait-state APB slave, pslverr on unmapped addresses
`timescale 1ns/1ns
`include "link_regs_defs.svh"

module serial_link_control_regs #(
    parameter int MODE_COUNT = 64   // Number of output mode codes
) (
    input wire logic pclk,                 // APB clock
    input wire logic presetn,              // APB reset, active low
    input wire logic psel,                 // APB select
    input wire logic penable,              // APB enable
    input wire logic pwrite,               // APB direction
    input wire logic [15:0] paddr,         // APB byte address
    input wire logic [31:0] pwdata,        // APB write data
    output logic [31:0] prdata,            // APB read data
    output logic pready,                   // APB ready
    output logic pslverr,                  // APB error
    input wire logic single_ended_sync_pin_n, // Sync pin, low requests sync
    input wire logic timestamp_pin_pair_n, // Timestamp pair receiver out, low requests sync
    input wire logic timestamp_receiver_enabled, // Timestamp receiver enable level
    input wire logic sysref_pulse,         // SYSREF event, same clock domain
    output logic link_reset_n,             // Link subsystem reset, active low
    output logic serializer_power_down,    // Serializer power down
    output logic link_clock_enable,        // Link clock gate enable
    output logic sync_request,             // Resynchronisation request to link
    output logic [5:0] output_mode_select, // Selected output mode
    output logic [8:0] effective_frames,   // Frames per multiframe in use, K
    output logic sample_format,            // 1 two's complement, 0 offset binary
    output logic scrambler_active,         // Scrambling in effect
    output logic [7:0] lane_enable,        // Lanes in use
    output logic [7:0] multiframe_count,   // Local multiframe counter
    output logic calibration_enable        // Converter calibration enable
);

    ////////////////////////////////////////////////////////////////////////////
    // Register storage
    logic link_enable_reg;
    logic [5:0] output_mode_reg;
    logic [7:0] frames_per_multiframe_minus_one_reg;
    logic software_sync_request_n_reg;
    logic [4:0] link_control_reg;
    logic calibration_enable_reg;
    logic sync_pin_stuck_reg;
    logic [3:0] pin_low_count_reg;
    link_regs_pkg::link_state_type state_reg;

    logic se_sync_n;
    logic ts_sync_n;
    logic ts_rx_en;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    pin_sync #(.RESET_LEVEL(1'b1)) sync_se (
        .pclk(pclk),
        .presetn(presetn),
        .pin_in(single_ended_sync_pin_n),
        .pin_out(se_sync_n)
    );
    pin_sync #(.RESET_LEVEL(1'b1)) sync_ts (
        .pclk(pclk),
        .presetn(presetn),
        .pin_in(timestamp_pin_pair_n),
        .pin_out(ts_sync_n)
    );
    pin_sync #(.RESET_LEVEL(1'b0)) sync_ts_en (
        .pclk(pclk),
        .presetn(presetn),
        .pin_in(timestamp_receiver_enabled),
        .pin_out(ts_rx_en)
    );

    ////////////////////////////////////////////////////////////////////////////
    // APB decode
    logic [13:0] word_index;
    logic addr_mapped;
    logic access;
    logic wr_en;

    assign word_index = paddr[15:2];
    assign access = psel && penable;
    assign wr_en = access && pwrite && addr_mapped;

    always_comb begin
        unique case (word_index)
            14'(`IDX_LINK_SUBSYSTEM_ENABLE),
            14'(`IDX_LINK_OUTPUT_MODE),
            14'(`IDX_FRAMES_PER_MULTIFRAME),
            14'(`IDX_SOFTWARE_SYNC_REQUEST),
            14'(`IDX_LINK_CONTROL),
            14'(`IDX_CALIBRATION_ENABLE),
            14'(`IDX_LINK_STATUS): addr_mapped = (paddr[1:0] == 2'h0);
            default: addr_mapped = 1'b0;
        endcase
    end

    function automatic logic hit(input logic [13:0] idx, input logic [11:0] target);
        hit = (idx == {2'h0, target});
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Mode decode: 64b/66b flag, E, F and lane count
    logic mode_is_64b66b;
    logic [2:0] mode_e;
    logic [3:0] mode_f;
    logic [3:0] mode_lanes;

    // Modes 0..15 use 8b/10b; higher codes use 64b/66b
    always_comb begin
        mode_is_64b66b = (output_mode_reg >= 6'h10) && (32'(output_mode_reg) < MODE_COUNT);
        mode_e = 3'h1;
        mode_f = 4'(4'h1 << output_mode_reg[1:0]);
        mode_lanes = 4'(4'h1 << output_mode_reg[3:2]);
        if (output_mode_reg[4]) begin
            mode_e = 3'(3'h1 << output_mode_reg[5]);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Link enable and calibration enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link_enable_reg <= 1'(`RST_LINK_SUBSYSTEM_ENABLE);
            calibration_enable_reg <= 1'(`RST_CALIBRATION_ENABLE);
        end else if (wr_en) begin
            if (hit(word_index, `IDX_LINK_SUBSYSTEM_ENABLE)) begin
                link_enable_reg <= pwdata[0];
            end
            if (hit(word_index, `IDX_CALIBRATION_ENABLE)) begin
                calibration_enable_reg <= pwdata[0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Configuration fields; writes land as issued, ordering is software's duty
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            output_mode_reg <= 6'(`RST_LINK_OUTPUT_MODE);
            frames_per_multiframe_minus_one_reg <= `RST_FRAMES_PER_MULTIFRAME;
            link_control_reg <= 5'(`RST_LINK_CONTROL);
        end else if (wr_en) begin
            if (hit(word_index, `IDX_LINK_OUTPUT_MODE)) begin
                output_mode_reg <= pwdata[5:0];
            end
            if (hit(word_index, `IDX_FRAMES_PER_MULTIFRAME)) begin
                frames_per_multiframe_minus_one_reg <= pwdata[7:0];
            end
            if (hit(word_index, `IDX_LINK_CONTROL)) begin
                link_control_reg <= pwdata[4:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            software_sync_request_n_reg <= 1'(`RST_SOFTWARE_SYNC_REQUEST);
        end else if (wr_en && hit(word_index, `IDX_SOFTWARE_SYNC_REQUEST)) begin
            software_sync_request_n_reg <= pwdata[0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sync request selection
    logic [1:0] sync_source;
    logic pin_request;
    logic request_now;

    assign sync_source = link_control_reg[`POS_SYNC_SEL_HI:`POS_SYNC_SEL_LO];

    always_comb begin
        unique case (sync_source)
            `SYNC_SRC_SINGLE_ENDED: pin_request = !se_sync_n;
            `SYNC_SRC_TIMESTAMP: pin_request = ts_rx_en && !ts_sync_n;
            default: pin_request = 1'b0;
        endcase
    end

    assign request_now = pin_request || !software_sync_request_n_reg;

    // Pin held low for long enough is flagged as stuck for status
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_low_count_reg <= 4'h0;
            sync_pin_stuck_reg <= 1'b0;
        end else if (pin_request) begin
            if (pin_low_count_reg != 4'hf) begin
                pin_low_count_reg <= pin_low_count_reg + 4'h1;
            end
            sync_pin_stuck_reg <= (pin_low_count_reg == 4'hf);
        end else begin
            pin_low_count_reg <= 4'h0;
            sync_pin_stuck_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Link state and control outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= link_regs_pkg::link_off;
        end else begin
            unique case (state_reg)
                link_regs_pkg::link_off: begin
                    if (link_enable_reg) begin
                        state_reg <= link_regs_pkg::link_running;
                    end
                end
                link_regs_pkg::link_running: begin
                    if (!link_enable_reg) begin
                        state_reg <= link_regs_pkg::link_off;
                    end
                end
                default: state_reg <= link_regs_pkg::link_off;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link_reset_n <= 1'b0;
            serializer_power_down <= 1'b1;
            link_clock_enable <= 1'b0;
        end else begin
            link_reset_n <= link_enable_reg;
            serializer_power_down <= !link_enable_reg;
            link_clock_enable <= link_enable_reg;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_request <= 1'b0;
        end else begin
            sync_request <= link_enable_reg && request_now;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Effective K and multiframe counter
    logic [8:0] k_value;
    logic [15:0] k_64b66b;

    always_comb begin
        k_64b66b = 16'((`EMB_BLOCK_SCALE * 16'(mode_e)) / 16'(mode_f));
        if (mode_is_64b66b) begin
            k_value = 9'(k_64b66b);
        end else begin
            k_value = 9'(frames_per_multiframe_minus_one_reg) + 9'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            effective_frames <= 9'h020;
        end else begin
            effective_frames <= k_value;
        end
    end

    // Counter held in reset while disabled so SYSREF cannot align it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            multiframe_count <= 8'h00;
        end else if (!link_enable_reg) begin
            multiframe_count <= 8'h00;
        end else if (sysref_pulse) begin
            multiframe_count <= 8'h00;
        end else if (9'(multiframe_count) + 9'h1 >= k_value) begin
            multiframe_count <= 8'h00;
        end else begin
            multiframe_count <= multiframe_count + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Format, scrambler, lane mapping
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            output_mode_select <= 6'(`RST_LINK_OUTPUT_MODE);
            sample_format <= 1'b1;
            scrambler_active <= 1'b1;
            lane_enable <= 8'h00;
            calibration_enable <= 1'b0;
        end else begin
            output_mode_select <= output_mode_reg;
            sample_format <= link_control_reg[`POS_SAMPLE_FORMAT];
            scrambler_active <= mode_is_64b66b || link_control_reg[`POS_SCRAMBLER_ENABLE];
            calibration_enable <= calibration_enable_reg;
            if (!link_enable_reg) begin
                lane_enable <= 8'h00;
            end else if (link_control_reg[`POS_UPPER_LANE_MAPPING] && mode_lanes <= 4'h4) begin
                lane_enable <= 8'(((8'h01 << mode_lanes) - 8'h01) << 4);
            end else begin
                lane_enable <= 8'((9'h001 << mode_lanes) - 9'h001);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // APB read and response
    logic [31:0] read_value;

    always_comb begin
        read_value = 32'h0000_0000;
        if (hit(word_index, `IDX_LINK_SUBSYSTEM_ENABLE)) begin
            read_value = {31'h0, link_enable_reg};
        end else if (hit(word_index, `IDX_LINK_OUTPUT_MODE)) begin
            read_value = {26'h0, output_mode_reg};
        end else if (hit(word_index, `IDX_FRAMES_PER_MULTIFRAME)) begin
            read_value = {24'h0, frames_per_multiframe_minus_one_reg};
        end else if (hit(word_index, `IDX_SOFTWARE_SYNC_REQUEST)) begin
            read_value = {31'h0, software_sync_request_n_reg};
        end else if (hit(word_index, `IDX_LINK_CONTROL)) begin
            read_value = {27'h0, link_control_reg};
        end else if (hit(word_index, `IDX_CALIBRATION_ENABLE)) begin
            read_value = {31'h0, calibration_enable_reg};
        end else if (hit(word_index, `IDX_LINK_STATUS)) begin
            read_value = {20'h0, effective_frames, sync_pin_stuck_reg, request_now,
                (state_reg == link_regs_pkg::link_running)};
        end
    end

    // Zero wait states: pready high in every access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !addr_mapped;
            prdata <= (psel && !penable && !pwrite && addr_mapped) ? read_value : 32'h0000_0000;
        end
    end

endmodule // serial_link_control_regs

// [hw/link_regs_defs.svh]
// Purpose: register offsets, field positions, reset values for the serial link control bank
// Assumes: APB byte addressing, one 32-bit word per register
// Notes: printed offsets are not multiples of four, so they are register indices
`ifndef LINK_REGS_DEFS_SVH
`define LINK_REGS_DEFS_SVH

// Register indices; byte address is four times the index
`define IDX_LINK_SUBSYSTEM_ENABLE 12'h200
`define IDX_LINK_OUTPUT_MODE 12'h201
`define IDX_FRAMES_PER_MULTIFRAME 12'h202
`define IDX_SOFTWARE_SYNC_REQUEST 12'h203
`define IDX_LINK_CONTROL 12'h204
`define IDX_CALIBRATION_ENABLE 12'h210
`define IDX_LINK_STATUS 12'h211

// Reset values
`define RST_LINK_SUBSYSTEM_ENABLE 8'h01
`define RST_LINK_OUTPUT_MODE 8'h00
`define RST_FRAMES_PER_MULTIFRAME 8'h1f
`define RST_SOFTWARE_SYNC_REQUEST 8'h01
`define RST_LINK_CONTROL 8'h03
`define RST_CALIBRATION_ENABLE 8'h00

// Field positions in link_control
`define POS_SCRAMBLER_ENABLE 0
`define POS_SAMPLE_FORMAT 1
`define POS_SYNC_SEL_LO 2
`define POS_SYNC_SEL_HI 3
`define POS_UPPER_LANE_MAPPING 4

// Writable masks, reserved bits read zero
`define MASK_ENABLE 8'h01
`define MASK_OUTPUT_MODE 8'h3f
`define MASK_FRAMES 8'hff
`define MASK_SYNC_REQ 8'h01
`define MASK_LINK_CONTROL 8'h1f

// Sync source codes
`define SYNC_SRC_SINGLE_ENDED 2'h0
`define SYNC_SRC_TIMESTAMP 2'h1
`define SYNC_SRC_SOFTWARE 2'h2

// Multiframe constant for 64b/66b
`define EMB_BLOCK_SCALE 16'h0100

`endif

// [hw/link_regs_pkg.sv]
// Purpose: types shared by the serial link control bank
// Assumes: nothing
// Notes: constants live in link_regs_defs.svh
package link_regs_pkg;
    typedef enum logic [1:0] {
        link_off,
        link_running
    } link_state_type;
endpackage

// [hw/pin_sync.sv]
// Purpose: two flip-flop synchroniser for one pin level
// Assumes: pin is asynchronous to pclk
// Notes: first stage feeds only the second
`timescale 1ns/1ns
module pin_sync #(
    parameter logic RESET_LEVEL = 1'b1
) (
    input wire logic pclk,     // Clock
    input wire logic presetn,  // Asynchronous reset, active low
    input wire logic pin_in,   // Raw pin level
    output logic pin_out       // Synchronised level
);
    logic stage1_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage1_reg <= RESET_LEVEL;
            pin_out <= RESET_LEVEL;
        end else begin
            stage1_reg <= pin_in;
            pin_out <= stage1_reg;
        end
    end
endmodule // pin_sync

// [verif/serial_link_control_regs_sva.sv]
// Purpose: port checks for serial_link_control_regs
// Assumes: one pclk domain, presetn asynchronous, active low
// Notes: bound to every instance of the bank
`timescale 1ns/1ns
module serial_link_control_regs_sva #(
    parameter int MODE_COUNT = 64 // Mode codes
) (
    input wire logic pclk, // Clock
    input wire logic presetn, // Reset, active low
    input wire logic pready, // APB ready
    input wire logic pslverr, // APB error
    input wire logic sysref_pulse, // SYSREF event
    input wire logic link_reset_n, // Link reset
    input wire logic serializer_power_down, // Power down
    input wire logic link_clock_enable, // Clock gate
    input wire logic sync_request, // Sync request
    input wire logic [5:0] output_mode_select, // Mode
    input wire logic [8:0] effective_frames, // K
    input wire logic scrambler_active, // Scrambling
    input wire logic [7:0] lane_enable, // Lanes
    input wire logic [7:0] multiframe_count // Counter
);
    logic [7:0] lane_mask;
    logic [8:0] k_64;
    logic is_64;
    always_comb begin
        lane_mask = 8'((16'h1 << (5'h1 << output_mode_select[3:2])) - 16'h1);
        k_64 = 9'((16'h100 << output_mode_select[5]) >> output_mode_select[1:0]);
        is_64 = output_mode_select >= 6'd16;
    end
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////////////////////////
    AST_OFF_PWR: assert property (!link_reset_n |-> serializer_power_down && !link_clock_enable && !lane_enable)
        else $error("link off but not powered down");
    AST_ON_PWR: assert property (link_reset_n |-> !serializer_power_down && link_clock_enable)
        else $error("link on but powered down");
    AST_OFF_CNT: assert property (!link_reset_n |-> multiframe_count == 8'h00)
        else $error("counter runs while link off");
    AST_SYSREF: assert property (link_reset_n && sysref_pulse |=> multiframe_count == 8'h00)
        else $error("sysref did not align counter");
    AST_K64: assert property ($stable(output_mode_select) && is_64 && |k_64 |-> effective_frames == k_64)
        else $error("wrong K in 64b66b mode");
    AST_SCR64: assert property ($stable(output_mode_select) && is_64 |-> scrambler_active)
        else $error("64b66b mode not scrambling");
    AST_LANES: assert property (link_reset_n && $past(link_reset_n) && $stable(output_mode_select) |->
        lane_enable == lane_mask || (output_mode_select[3:2] != 2'h3 && lane_enable == 8'(lane_mask << 4)))
        else $error("lane map wrong");
    AST_READY: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    AST_ERR: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    cover property (link_reset_n && sysref_pulse);
    cover property (link_reset_n && is_64);
    cover property (pslverr);
    cover property (sync_request);
endmodule // serial_link_control_regs_sva

bind serial_link_control_regs serial_link_control_regs_sva #(.MODE_COUNT(MODE_COUNT)) sva (.*);

// [verif/sync_receiver_model.sv]
// Purpose: far-end receiver driving the sync request pins
// Assumes: pins idle high, low requests sync
// Notes: requests sync for a while after each link start
`timescale 1ns/1ns
module sync_receiver_model #(
    parameter int ALIGN_CYCLES = 6 // Alignment time
) (
    input wire logic pclk, // Clock
    input wire logic presetn, // Reset, active low
    input wire logic link_reset_n, // Link reset
    input wire logic route_to_timestamp, // Use pin pair
    input wire logic stuck_low, // Fault: pin stuck
    output logic single_ended_sync_pin_n, // Sync pin
    output logic timestamp_pin_pair_n // Pin pair
);
    int align_count;
    logic req_n;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            align_count <= 0;
        end else if (!link_reset_n) begin
            align_count <= ALIGN_CYCLES;
        end else if (align_count != 0) begin
            align_count <= align_count - 1;
        end
    end
    assign req_n = !(stuck_low || (link_reset_n && align_count != 0));
    assign single_ended_sync_pin_n = route_to_timestamp ? 1'b1 : req_n;
    assign timestamp_pin_pair_n = route_to_timestamp ? req_n : 1'b1;
endmodule // sync_receiver_model

// [verif/tb_top.sv]
// Purpose: register and link checks of serial_link_control_regs
// Assumes: zero wait-state APB, pin to request in three edges
// Notes: ports connected by matching names
`timescale 1ns/1ns
`include "link_regs_defs.svh"
module tb_top;
    localparam logic [15:0] a_en = 16'(`IDX_LINK_SUBSYSTEM_ENABLE) << 2;
    localparam logic [15:0] a_mode = 16'(`IDX_LINK_OUTPUT_MODE) << 2;
    localparam logic [15:0] a_frames = 16'(`IDX_FRAMES_PER_MULTIFRAME) << 2;
    localparam logic [15:0] a_sync = 16'(`IDX_SOFTWARE_SYNC_REQUEST) << 2;
    localparam logic [15:0] a_ctrl = 16'(`IDX_LINK_CONTROL) << 2;
    localparam logic [15:0] a_cal = 16'(`IDX_CALIBRATION_ENABLE) << 2;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [15:0] paddr = 16'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic sysref_pulse = 1'b0, timestamp_receiver_enabled = 1'b0, route_to_timestamp = 1'b0, stuck_low = 1'b0;
    logic pready, pslverr, single_ended_sync_pin_n, timestamp_pin_pair_n, link_reset_n, serializer_power_down;
    logic link_clock_enable, sync_request, sample_format, scrambler_active, calibration_enable, err;
    logic [5:0] output_mode_select, m;
    logic [8:0] effective_frames, k;
    logic [7:0] lane_enable, multiframe_count, ctl, lmask, mx;
    logic [5:0] modes [8] = '{6'h00, 6'h05, 6'h0a, 6'h13, 6'h11, 6'h12, 6'h1c, 6'h31};
    int bad_count = 0, samples_checked = 0;
    always #4 pclk = ~pclk;
    serial_link_control_regs #(.MODE_COUNT(64)) dut (.*);
    sync_receiver_model #(.ALIGN_CYCLES(6)) far_end (.*);
    ////////////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        if (bad_count == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 16 && pready !== 1'b1; n++) begin
            @(posedge pclk);
        end
        if (n == 16) begin
            check(32'h0, 32'h1, "no pready");
            tally_and_finish();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdchk(input logic [15:0] a, input logic [7:0] exp, input string what);
        apb(1'b0, a, 32'h0);
        check(rd, 32'(exp), what);
    endtask
    task automatic wait_sync(input logic v, input string what);
        for (int n = 0; n < 20 && sync_request !== v; n++) begin
            @(posedge pclk);
        end
        check(32'(sync_request), 32'(v), what);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdchk(a_en, `RST_LINK_SUBSYSTEM_ENABLE, "enable reset");
        rdchk(a_mode, `RST_LINK_OUTPUT_MODE, "mode reset");
        rdchk(a_frames, `RST_FRAMES_PER_MULTIFRAME, "frames reset");
        rdchk(a_sync, `RST_SOFTWARE_SYNC_REQUEST, "sync reset");
        rdchk(a_ctrl, `RST_LINK_CONTROL, "control reset");
        check({22'h0, effective_frames, sample_format}, {22'h0, 9'd32, 1'b1}, "reset K, format");
        apb(1'b0, 16'h0900, 32'h0);
        check({err, rd[30:0]}, 32'h8000_0000, "unmapped read");
        wr(a_en, 32'h0);
        sysref_pulse <= 1'b1;
        @(posedge pclk);
        sysref_pulse <= 1'b0;
        repeat (3) @(posedge pclk);
        check({link_reset_n, link_clock_enable, serializer_power_down, lane_enable}, 32'h100, "off outputs");
        check(32'(multiframe_count), 32'h0, "counter held");
        for (int i = 0; i < 8; i++) begin
            m = modes[i];
            ctl = i[0] ? 8'h1a : 8'h09;
            lmask = 8'((16'h1 << (5'h1 << m[3:2])) - 16'h1);
            k = (m >= 6'd16) ? 9'((16'h100 << m[5]) >> m[1:0]) : 9'd16;
            wr(a_en, 32'h0);
            wr(a_cal, 32'h0);
            wr(a_mode, 32'(m));
            wr(a_frames, 32'h0f);
            wr(a_ctrl, 32'(ctl));
            wr(a_cal, 32'h1);
            wr(a_en, 32'h1);
            sysref_pulse <= 1'b1;
            @(posedge pclk);
            sysref_pulse <= 1'b0;
            check(32'(output_mode_select), 32'(m), "mode");
            check(32'(calibration_enable), 32'h1, "calibration");
            check(32'(effective_frames), 32'(k), "K");
            check({sample_format, scrambler_active}, {ctl[1], ctl[0] | (m >= 6'd16)}, "format, scrambler");
            check(32'(lane_enable), 32'(ctl[4] ? lmask << 4 : lmask), "lanes");
            mx = 8'h0;
            repeat (40) begin
                @(posedge pclk);
                mx = (multiframe_count > mx) ? multiframe_count : mx;
            end
            if (m < 6'd16) check(32'(mx), 32'd15, "counter wrap");
        end
        wr(a_en, 32'h0);
        wr(a_ctrl, 32'h03);
        wr(a_en, 32'h1);
        wait_sync(1'b1, "pin request");
        wait_sync(1'b0, "pin release");
        route_to_timestamp <= 1'b1;
        timestamp_receiver_enabled <= 1'b1;
        wr(a_en, 32'h0);
        wr(a_ctrl, 32'h07);
        wr(a_en, 32'h1);
        wait_sync(1'b1, "pair request");
        wait_sync(1'b0, "pair release");
        wr(a_sync, 32'h0);
        wait_sync(1'b1, "software request");
        wr(a_sync, 32'h1);
        wait_sync(1'b0, "software release");
        timestamp_receiver_enabled <= 1'b0;
        stuck_low <= 1'b1;
        repeat (8) @(posedge pclk);
        check(32'(sync_request), 32'h0, "pair receiver off");
        route_to_timestamp <= 1'b0;
        wr(a_en, 32'h0);
        wr(a_ctrl, 32'h03);
        wr(a_en, 32'h1);
        repeat (8) @(posedge pclk);
        check(32'(sync_request), 32'h1, "stuck pin holds");
        wr(a_en, 32'h0);
        wr(a_ctrl, 32'h0b);
        wr(a_en, 32'h1);
        repeat (4) @(posedge pclk);
        check(32'(sync_request), 32'h0, "stuck pin released");
        wr(a_sync, 32'h0);
        wait_sync(1'b1, "software only request");
        tally_and_finish();
    end
endmodule // tb_top
